// >>> src/flash_pkg.sv
`default_nettype none
package flash_pkg;

	// ==================================================================
	// opcodes
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_RDFSR = 8'h70;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_RDCFG = 8'hb5;
	localparam logic [7:0] OP_WRCFG = 8'hb1;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_QREAD = 8'heb;
	localparam logic [7:0] OP_DREAD = 8'hbb;
	localparam logic [7:0] OP_QPROG = 8'h12;
	localparam logic [7:0] OP_DPROG = 8'hd2;

	// ==================================================================
	// configuration word and status layout
	localparam int          CFG_W        = 16;
	localparam logic [15:0] CFG_RESET    = 16'hffff;
	localparam int          DUMMY_MSB    = 15;
	localparam int          DUMMY_LSB    = 12;
	localparam int          CFG_ADDR_BIT = 0;
	localparam logic [11:0] CFG_FILL     = 12'hfff;
	localparam logic [3:0]  DUMMY_DEF_LO = 4'h0;
	localparam logic [3:0]  DUMMY_DEF_HI = 4'hf;
	localparam logic [3:0]  DUMMY_DEF_X1 = 4'h8;
	localparam logic [3:0]  DUMMY_DEF_X4 = 4'ha;
	localparam logic [3:0]  DUMMY_DUAL   = 4'ha;
	localparam int          SR_WEL_BIT   = 1;
	localparam int          FSR_RDY_BIT  = 7;
	localparam int          FSR_ADDR_BIT = 0;

	// ==================================================================
	// framing
	localparam logic [5:0] ADDR_BITS  = 6'h20;
	localparam logic [5:0] BYTE_BITS  = 6'h08;
	localparam int         PAGE_BYTES = 256;
	localparam logic [8:0] CFG_BYTES  = 9'h002;

	// ==================================================================
	// serial clock divider: half period in core cycles
	localparam int CORE_MHZ      = 50;
	localparam int SCLK_FMAX_MHZ = 100;
	localparam int SCLK_DIV_FMAX = (CORE_MHZ + 2 * SCLK_FMAX_MHZ - 1) / (2 * SCLK_FMAX_MHZ);
	// two core cycles per half period leave room for the input synchroniser
	localparam int SCLK_DIV_DEF  = (SCLK_DIV_FMAX > 2) ? SCLK_DIV_FMAX : 2;

	typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} lane_t;

	function automatic logic [5:0] lane_step(lane_t l);
		case (l)
			LANE_X2: lane_step = 6'h02;
			LANE_X4: lane_step = 6'h04;
			default: lane_step = 6'h01;
		endcase
	endfunction

endpackage
`default_nettype wire

// >>> src/flash_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
	logic       serial_clock_pin;
	logic       select_low;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe;
	logic [3:0] dq_lines;
	logic       serial_in_line;
	logic       serial_out_line;

	// undriven lines float high through the board pull-ups
	assign dq_lines = (host_dq_oe & host_dq_o) | (~host_dq_oe & dev_dq_oe & dev_dq_o) |
		(~host_dq_oe & ~dev_dq_oe);
	assign serial_in_line  = dq_lines[0];
	assign serial_out_line = dq_lines[1];

	modport device_end (
		input  serial_clock_pin,
		input  select_low,
		input  dq_lines,
		output dev_dq_o,
		output dev_dq_oe
	);

	modport host_end (
		output serial_clock_pin,
		output select_low,
		output host_dq_o,
		output host_dq_oe,
		input  dq_lines
	);
endinterface
`default_nettype wire

// >>> src/flash_device_end.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Contract
// [R1] config bits 15:12 give dummy count 1..14
// [R2] dummy code 0000 or 1111 means default
// [R3] default dummy: 8 single, 10 quad
// [R4] host writes ones into bits 11:5
// [R5] host writes ones into bits 3:1
// [R6] config read: opcode in, data out lines
// [R7] after sixteen config bits, output zeros
// [R8] host may end config read anytime
// [R9] host sends write enable before config write; the host skips it when cmd_wr_bytes is zero
// [R10] host sends dummy code with ones elsewhere
// [R11] status reads: no address, no dummy, streamed
// [R12] config read: no address, two bytes
// [R13] config write: no address, two bytes
// [R14] quad read: four address bytes, dummies, stream
// [R15] dual read: four address bytes, ten dummies
// [R16] quad page write: address, 1..256 bytes
// [R17] dual page write: address, 1..256 bytes
// [R18] all fields shifted most significant first
// [R19] page write keeps only last 256 bytes
// [R20] write enable sets the latch bit
// [R21] config write without write enable ignored
module flash_device_end (
	flash_link_if.device_end                  link,
	input  wire logic                         core_clk,
	input  wire logic                         srst,
	output logic [flash_pkg::CFG_W-1:0]       cfg_word,
	output logic                              write_latch,
	output logic                              cfg_updated
);
	import flash_pkg::*;

	typedef enum logic [2:0] {ST_OP, ST_ADDR, ST_DUMMY, ST_DOUT, ST_DIN, ST_IGN} dst_t;
	typedef enum logic [1:0] {SRC_STATUS, SRC_FLAG, SRC_CFG, SRC_MEM} src_t;

	typedef struct packed {
		logic        rst_meta;
		logic        rst_s;
		dst_t        st;
		lane_t       ln;
		src_t        src;
		logic [5:0]  cnt;
		logic [7:0]  op;
		logic [31:0] sr;
		logic [31:0] addr;
		logic [3:0]  dummy;
		logic [7:0]  osr;
		logic [8:0]  nbytes;
		logic [15:0] cfg;
		logic [15:0] cfg_new;
		logic        wel;
		logic        wrote;
		logic [3:0]  dq_o;
		logic [3:0]  dq_oe;
		logic        cfg_tgl;
	} link_t;

	typedef struct packed {
		logic        tgl_meta;
		logic        tgl_s;
		logic        tgl_seen;
		logic        wel_meta;
		logic        wel_s;
		logic [15:0] cfg;
		logic        updated;
	} core_t;

	link_t q, d;
	core_t c_q, c_d;
	logic [7:0] page_mem [PAGE_BYTES];
	logic       mem_we;
	logic [7:0] mem_a;
	logic [7:0] mem_wd;

	// ==================================================================
	// helpers
	function automatic logic [3:0] eff_dummy(logic [3:0] code, logic [3:0] dflt);
		if (code == DUMMY_DEF_LO || code == DUMMY_DEF_HI) begin // [R2]
			eff_dummy = dflt;
		end else begin
			eff_dummy = code; // [R1]
		end
	endfunction

	function automatic logic [7:0] out_byte(src_t s, logic [8:0] idx, logic [7:0] a, logic [15:0] c,
		logic w);
		out_byte = 8'h00;
		case (s)
			SRC_STATUS: out_byte[SR_WEL_BIT] = w;
			SRC_FLAG: begin
				out_byte[FSR_RDY_BIT]  = 1'h1;
				out_byte[FSR_ADDR_BIT] = ~c[CFG_ADDR_BIT];
			end
			SRC_CFG: begin
				if (idx == 9'h000) out_byte = c[15:8]; // [R12]
				else if (idx == 9'h001) out_byte = c[7:0];
				else out_byte = 8'h00; // [R7]
			end
			default: out_byte = page_mem[a];
		endcase
	endfunction

	// ==================================================================
	// link side, on the serial clock
	always_comb begin
		logic [31:0] sr_in;
		logic [5:0]  step;
		logic [3:0]  dcode;
		logic        load;
		sr_in  = '0;
		step   = lane_step(q.ln);
		dcode  = q.cfg[DUMMY_MSB:DUMMY_LSB];
		load   = 1'h0;
		d      = q;
		mem_we = 1'h0;
		mem_a  = q.addr[7:0];
		mem_wd = 8'h00;
		case (q.ln) // [R18]
			LANE_X2: sr_in = {q.sr[29:0], link.dq_lines[1:0]};
			LANE_X4: sr_in = {q.sr[27:0], link.dq_lines};
			default: sr_in = {q.sr[30:0], link.dq_lines[0]}; // [R6]
		endcase
		if (link.select_low) begin
			// frame over: commit what a completed write delivered
			if (q.st == ST_DIN && q.wrote) begin
				d.wel = 1'h0;
				if (q.op == OP_WRCFG && q.nbytes == CFG_BYTES) begin // [R13]
					d.cfg     = q.cfg_new;
					d.cfg_tgl = ~q.cfg_tgl;
				end
			end
			d.st     = ST_OP;
			d.ln     = LANE_X1;
			d.cnt    = '0;
			d.nbytes = '0;
			d.wrote  = 1'h0;
		end else begin
			case (q.st)
				ST_OP: begin
					d.sr  = sr_in;
					d.cnt = q.cnt + 6'h01;
					if (q.cnt == 6'h07) begin
						d.op    = sr_in[7:0];
						d.cnt   = '0;
						d.st    = ST_IGN;
						d.dummy = 4'h0;
						case (sr_in[7:0])
							OP_WREN: d.wel = 1'h1; // [R20]
							OP_WRDI: d.wel = 1'h0;
							OP_RDSR: begin
								d.src = SRC_STATUS; // [R11]
								load  = 1'h1;
							end
							OP_RDFSR: begin
								d.src = SRC_FLAG; // [R11]
								load  = 1'h1;
							end
							OP_RDCFG: begin
								d.src = SRC_CFG; // [R12]
								load  = 1'h1;
							end
							OP_WRCFG: if (q.wel) d.st = ST_DIN; // [R21]
							OP_READ: d.st = ST_ADDR;
							OP_FREAD: begin
								d.st    = ST_ADDR;
								d.dummy = eff_dummy(dcode, DUMMY_DEF_X1); // [R3]
							end
							OP_QREAD: begin
								d.st    = ST_ADDR; // [R14]
								d.ln    = LANE_X4;
								d.dummy = eff_dummy(dcode, DUMMY_DEF_X4); // [R3]
							end
							OP_DREAD: begin
								d.st    = ST_ADDR; // [R15]
								d.ln    = LANE_X2;
								d.dummy = DUMMY_DUAL;
							end
							OP_QPROG: if (q.wel) begin
								d.st = ST_ADDR; // [R16]
								d.ln = LANE_X4;
							end
							OP_DPROG: if (q.wel) begin
								d.st = ST_ADDR; // [R17]
								d.ln = LANE_X2;
							end
							default: d.st = ST_IGN;
						endcase
					end
				end
				ST_ADDR: begin
					d.sr  = sr_in;
					d.cnt = q.cnt + step;
					if (q.cnt + step == ADDR_BITS) begin
						d.addr = sr_in;
						d.cnt  = '0;
						if (q.op == OP_QPROG || q.op == OP_DPROG) begin
							d.st = ST_DIN;
						end else if (q.dummy == 4'h0) begin
							d.src = SRC_MEM;
							load  = 1'h1;
						end else begin
							d.st = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					d.dummy = q.dummy - 4'h1;
					if (q.dummy == 4'h1) begin
						d.src = SRC_MEM;
						load  = 1'h1;
					end
				end
				ST_DOUT: begin
					d.osr = q.osr << step;
					d.cnt = q.cnt + step;
					if (q.cnt + step == BYTE_BITS) load = 1'h1; // [R11]
				end
				ST_DIN: begin
					d.sr  = sr_in;
					d.cnt = q.cnt + step;
					if (q.cnt + step == BYTE_BITS) begin
						d.cnt   = '0;
						d.wrote = 1'h1; // [R19]
						if (q.nbytes != 9'h1ff) d.nbytes = q.nbytes + 9'h001;
						if (q.op == OP_WRCFG) begin
							d.cfg_new = {q.cfg_new[7:0], sr_in[7:0]};
						end else begin
							// the buffer index wraps, so only the last 256 bytes survive
							mem_we = 1'h1; // [R19]
							mem_wd = sr_in[7:0];
							d.addr = q.addr + 32'h1;
						end
					end
				end
				default: d.st = ST_IGN;
			endcase
		end
		if (load) begin
			if (q.st == ST_OP || q.st == ST_ADDR || q.st == ST_DUMMY) d.nbytes = '0;
			d.osr = out_byte(d.src, d.nbytes, d.addr[7:0], q.cfg, q.wel);
			if (d.nbytes != 9'h1ff) d.nbytes = d.nbytes + 9'h001;
			if (d.src == SRC_MEM) d.addr = d.addr + 32'h1;
			d.cnt = '0;
			d.st  = ST_DOUT;
		end
		d.dq_o  = 4'h0;
		d.dq_oe = 4'h0;
		if (d.st == ST_DOUT) begin
			case (d.ln)
				LANE_X2: begin
					d.dq_o  = {2'h0, d.osr[7:6]};
					d.dq_oe = 4'h3;
				end
				LANE_X4: begin
					d.dq_o  = d.osr[7:4];
					d.dq_oe = 4'hf;
				end
				default: begin
					d.dq_o  = {2'h0, d.osr[7], 1'h0}; // [R6]
					d.dq_oe = 4'h2;
				end
			endcase
		end
		if (q.rst_s) begin
			d     = link_t'('0);
			d.cfg = CFG_RESET;
		end
		d.rst_meta = srst;
		d.rst_s    = q.rst_meta;
	end

	always_ff @(posedge link.serial_clock_pin) begin
		q <= d;
	end

	always_ff @(posedge link.serial_clock_pin) begin
		if (mem_we) page_mem[mem_a] <= mem_wd;
	end

	assign link.dev_dq_o  = q.dq_o;
	assign link.dev_dq_oe = q.dq_oe;

	// ==================================================================
	// user side; the word is stable while its toggle crosses
	always_comb begin
		c_d          = c_q;
		c_d.tgl_meta = q.cfg_tgl;
		c_d.tgl_s    = c_q.tgl_meta;
		c_d.wel_meta = q.wel;
		c_d.wel_s    = c_q.wel_meta;
		c_d.updated  = 1'h0;
		if (c_q.tgl_s != c_q.tgl_seen) begin
			c_d.tgl_seen = c_q.tgl_s;
			c_d.cfg      = q.cfg;
			c_d.updated  = 1'h1;
		end
		if (srst) begin
			c_d     = core_t'('0);
			c_d.cfg = CFG_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		c_q <= c_d;
	end

	assign cfg_word    = c_q.cfg;
	assign write_latch = c_q.wel_s;
	assign cfg_updated = c_q.updated;
endmodule
`default_nettype wire

// >>> src/flash_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_end #(
	parameter int DIV = flash_pkg::SCLK_DIV_DEF
) (
	flash_link_if.host_end           link,
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire logic [7:0]          cmd_op,
	input  wire logic                cmd_use_addr,
	input  wire logic [31:0]         cmd_addr,
	input  wire flash_pkg::lane_t    cmd_lanes,
	input  wire logic [3:0]          cmd_dummy,
	input  wire logic [8:0]          cmd_wr_bytes,
	input  wire logic [15:0]         cmd_rd_bytes,
	input  wire logic [3:0]          cfg_code,
	input  wire logic [7:0]          wr_byte,
	output logic                     wr_take,
	output logic [7:0]               rd_byte,
	output logic                     rd_valid
);
	import flash_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_GAP, H_OP, H_ADDR, H_DUMMY, H_WR, H_RD, H_END} hst_t;

	typedef struct packed {
		hst_t        st;
		logic [7:0]  div;
		logic        sclk;
		logic        sel_n;
		logic [3:0]  dq_o;
		logic [3:0]  dq_oe;
		lane_t       ln;
		lane_t       cln;
		logic [5:0]  cnt;
		logic [31:0] sr;
		logic [7:0]  op;
		logic        use_addr;
		logic [31:0] addr;
		logic [3:0]  dummy;
		logic [8:0]  wr_left;
		logic [15:0] rd_left;
		logic [3:0]  code;
		logic        pre_wren;
		logic        ready;
		logic [7:0]  rd_byte;
		logic        rd_valid;
		logic        wr_take;
		logic [3:0]  in_meta;
		logic [3:0]  in_s;
	} host_t;

	host_t q, d;

	always_comb begin
		logic       tick;
		logic       rise;
		logic       fall;
		logic       go_data;
		logic [5:0] step;
		tick       = (q.div == 8'(DIV - 1));
		rise       = tick && !q.sclk;
		fall       = tick && q.sclk;
		go_data    = 1'h0;
		step       = lane_step(q.ln);
		d          = q;
		d.div      = tick ? 8'h00 : q.div + 8'h01;
		d.sclk     = tick ? ~q.sclk : q.sclk;
		d.rd_valid = 1'h0;
		d.wr_take  = 1'h0;
		d.in_meta  = link.dq_lines;
		d.in_s     = q.in_meta;
		case (q.st)
			H_IDLE: begin
				d.ready = 1'h1;
				if (cmd_valid && q.ready) begin
					d.ready    = 1'h0;
					d.use_addr = cmd_use_addr;
					d.addr     = cmd_addr;
					d.cln      = cmd_lanes;
					d.dummy    = cmd_dummy;
					d.wr_left  = (cmd_op == OP_WRCFG) ? CFG_BYTES : cmd_wr_bytes;
					d.rd_left  = cmd_rd_bytes;
					d.code     = cfg_code;
					// a config write goes out behind its own write enable; a zero
					// byte count leaves it off so the device guard can be exercised
					d.pre_wren = (cmd_op == OP_WRCFG) && (cmd_wr_bytes != 9'h000); // [R9]
					d.op       = ((cmd_op == OP_WRCFG) && (cmd_wr_bytes != 9'h000)) ? OP_WREN : cmd_op;
					d.cnt      = '0;
					d.st       = H_GAP;
				end
			end
			H_GAP: begin
				// one rising edge with select high lets the device end its frame
				if (rise) d.cnt = 6'h01;
				if (fall && q.cnt != 6'h00) begin
					d.sel_n = 1'h0;
					d.ln    = LANE_X1;
					d.sr    = {q.op, 24'h000000}; // [R6]
					d.cnt   = '0;
					d.st    = H_OP;
				end
			end
			H_OP: if (rise) begin
				d.sr  = q.sr << step; // [R18]
				d.cnt = q.cnt + step;
				if (q.cnt + step == BYTE_BITS) begin
					d.cnt = '0;
					d.ln  = q.cln;
					if (q.pre_wren) begin
						d.st = H_END;
					end else if (q.use_addr) begin
						d.sr = q.addr;
						d.st = H_ADDR;
					end else begin
						go_data = 1'h1;
					end
				end
			end
			H_ADDR: if (rise) begin
				d.sr  = q.sr << step;
				d.cnt = q.cnt + step;
				if (q.cnt + step == ADDR_BITS) begin
					d.cnt   = '0;
					go_data = 1'h1;
				end
			end
			H_DUMMY: if (rise) begin
				d.dummy = q.dummy - 4'h1;
				if (q.dummy == 4'h1) d.st = (q.rd_left != 16'h0000) ? H_RD : H_END;
			end
			H_WR: if (rise) begin
				d.sr  = q.sr << step;
				d.cnt = q.cnt + step;
				if (q.cnt + step == BYTE_BITS) begin
					d.cnt     = '0;
					d.wr_left = q.wr_left - 9'h001;
					if (q.wr_left == 9'h001) begin
						d.st = H_END;
					end else if (q.op != OP_WRCFG) begin
						d.sr[31:24] = wr_byte;
						d.wr_take   = 1'h1;
					end
				end
			end
			H_RD: if (rise) begin
				case (q.ln)
					LANE_X2: d.sr = {q.sr[29:0], q.in_s[1:0]};
					LANE_X4: d.sr = {q.sr[27:0], q.in_s};
					default: d.sr = {q.sr[30:0], q.in_s[1]};
				endcase
				d.cnt = q.cnt + step;
				if (q.cnt + step == BYTE_BITS) begin
					d.cnt      = '0;
					d.rd_byte  = d.sr[7:0];
					d.rd_valid = 1'h1;
					d.rd_left  = q.rd_left - 16'h0001;
					if (q.rd_left == 16'h0001) d.st = H_END; // [R8]
				end
			end
			H_END: if (fall) begin
				d.sel_n = 1'h1;
				d.cnt   = '0;
				if (q.pre_wren) begin
					d.pre_wren = 1'h0;
					d.op       = OP_WRCFG;
					d.st       = H_GAP;
				end else begin
					d.st = H_IDLE;
				end
			end
			default: d.st = H_IDLE;
		endcase
		if (go_data) begin
			if (q.dummy != 4'h0) begin
				d.st = H_DUMMY;
			end else if (q.wr_left != 9'h000) begin
				d.st = H_WR;
				if (q.op == OP_WRCFG) begin
					d.sr = {q.code, CFG_FILL, 16'h0000}; // [R4] [R5] [R10]
				end else begin
					d.sr      = {wr_byte, 24'h000000};
					d.wr_take = 1'h1;
				end
			end else if (q.rd_left != 16'h0000) begin
				d.st = H_RD;
			end else begin
				d.st = H_END;
			end
		end
		if (fall) begin
			d.dq_o  = 4'h0;
			d.dq_oe = 4'h0;
			if (d.st == H_OP || d.st == H_ADDR || d.st == H_WR) begin
				case (d.ln)
					LANE_X2: begin
						d.dq_o  = {2'h0, d.sr[31:30]};
						d.dq_oe = 4'h3;
					end
					LANE_X4: begin
						d.dq_o  = d.sr[31:28];
						d.dq_oe = 4'hf;
					end
					default: begin
						d.dq_o  = {3'h0, d.sr[31]};
						d.dq_oe = 4'h1;
					end
				endcase
			end
		end
		if (srst) begin
			d       = host_t'('0);
			d.sel_n = 1'h1;
			// the clock keeps running in reset so the device link side can clear;
			// a reset cycle that finds select not high parks it at zero
			if (q.sel_n) begin
				d.div  = tick ? 8'h00 : q.div + 8'h01;
				d.sclk = tick ? ~q.sclk : q.sclk;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign link.serial_clock_pin = q.sclk;
	assign link.select_low       = q.sel_n;
	assign link.host_dq_o        = q.dq_o;
	assign link.host_dq_oe       = q.dq_oe;
	assign cmd_ready             = q.ready;
	assign wr_take               = q.wr_take;
	assign rd_byte               = q.rd_byte;
	assign rd_valid              = q.rd_valid;
endmodule
`default_nettype wire

// >>> verif/flash_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// link checker: watches the wire between the two ends
module flash_link_checker
	import flash_pkg::*;
#(
	parameter int DIV = 2
) (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       serial_clock_pin,
	input  wire logic       select_low,
	input  wire logic [3:0] host_dq_oe,
	input  wire logic [3:0] dev_dq_oe,
	input  wire logic       serial_in_line,
	input  wire logic       serial_out_line
);
	logic       clk_prev_q;
	logic       seen_q;
	logic [7:0] half_q;
	logic [5:0] rise_q;
	logic [7:0] op_q;

	// the first toggle after reset has no full half period behind it
	always_ff @(posedge core_clk) begin
		clk_prev_q <= serial_clock_pin;
		half_q     <= (serial_clock_pin != clk_prev_q) ? 8'h00 : half_q + 8'h01;
		seen_q     <= srst ? 1'b0 : (seen_q | (serial_clock_pin != clk_prev_q));
	end

	// rises counted within a frame, opcode caught from the first eight
	always_ff @(posedge serial_clock_pin) begin
		if (select_low) begin
			rise_q <= 6'h00;
			op_q   <= 8'h00;
		end else begin
			rise_q <= (rise_q == 6'h3f) ? rise_q : rise_q + 6'h01;
			op_q   <= (rise_q < 6'h08) ? {op_q[6:0], serial_in_line} : op_q;
		end
	end

	// ==================================================================
	// properties
	property p_half_period;
		@(posedge core_clk) disable iff (srst)
		seen_q && (serial_clock_pin != clk_prev_q) |-> half_q == 8'(DIV - 1);
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("serial clock half period wrong");

	property p_rise_steady;
		@(posedge core_clk) disable iff (srst)
		$rose(serial_clock_pin) |-> $stable(select_low) && $stable(host_dq_oe);
	endproperty
	a_rise_steady: assert property (p_rise_steady)
		else $error("host changed lines at a rising serial clock");

	property p_idle_host_off;
		@(posedge core_clk) disable iff (srst)
		select_low |-> host_dq_oe == 4'h0;
	endproperty
	a_idle_host_off: assert property (p_idle_host_off)
		else $error("host drives lines outside a frame");

	property p_idle_dev_off;
		@(posedge core_clk) disable iff (srst)
		select_low [*8] |-> dev_dq_oe == 4'h0;
	endproperty
	a_idle_dev_off: assert property (p_idle_dev_off)
		else $error("device drives lines outside a frame");

	property p_opcode_quiet;
		@(posedge serial_clock_pin) disable iff (srst)
		!select_low && rise_q < 6'h08 |-> dev_dq_oe == 4'h0;
	endproperty
	a_opcode_quiet: assert property (p_opcode_quiet)
		else $error("device drives during opcode");

	property p_cfg_lane;
		@(posedge serial_clock_pin) disable iff (srst)
		!select_low && op_q == OP_RDCFG && rise_q >= 6'h09 |-> dev_dq_oe == 4'h2;
	endproperty
	a_cfg_lane: assert property (p_cfg_lane)
		else $error("config read not on the output line");

	property p_cfg_tail;
		@(posedge serial_clock_pin) disable iff (srst)
		!select_low && op_q == OP_RDCFG && rise_q >= 6'h19 |-> serial_out_line == 1'b0;
	endproperty
	a_cfg_tail: assert property (p_cfg_tail)
		else $error("config read tail not zero");

	property p_write_quiet;
		@(posedge serial_clock_pin) disable iff (srst)
		!select_low && rise_q >= 6'h09 && (op_q == OP_WRCFG || op_q == OP_QPROG || op_q == OP_DPROG)
			|-> dev_dq_oe == 4'h0;
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("device drives during a write");
endmodule
`default_nettype wire

// >>> verif/serial_flash_config_register_ops_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_config_register_ops_test;
	import flash_pkg::*;
	logic        core_clk, srst, cmd_valid, cmd_ready, cmd_use_addr, wr_take, rd_valid;
	logic        write_latch, cfg_updated;
	logic [7:0]  cmd_op, wr_byte, rd_byte;
	logic [31:0] cmd_addr, a;
	lane_t       cmd_lanes;
	logic [3:0]  cmd_dummy, cfg_code, code;
	logic [8:0]  cmd_wr_bytes;
	logic [15:0] cmd_rd_bytes, cfg_word;
	logic [7:0]  wbuf [0:511];
	logic [7:0]  mem [0:255];
	logic [7:0]  rq [$];
	int          err_count, checks_done, upd_count, cfg_writes, widx, n;

	flash_link_if link ();
	flash_device_end flash_device_end_i (.link(link.device_end), .core_clk(core_clk), .srst(srst),
		.cfg_word(cfg_word), .write_latch(write_latch), .cfg_updated(cfg_updated));
	flash_host_end #(.DIV(2)) flash_host_end_i (.link(link.host_end), .core_clk(core_clk), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_use_addr(cmd_use_addr),
		.cmd_addr(cmd_addr), .cmd_lanes(cmd_lanes), .cmd_dummy(cmd_dummy), .cmd_wr_bytes(cmd_wr_bytes),
		.cmd_rd_bytes(cmd_rd_bytes), .cfg_code(cfg_code), .wr_byte(wr_byte), .wr_take(wr_take),
		.rd_byte(rd_byte), .rd_valid(rd_valid));
	flash_link_checker #(.DIV(2)) flash_link_checker_i (.core_clk(core_clk), .srst(srst),
		.serial_clock_pin(link.serial_clock_pin), .select_low(link.select_low), .host_dq_oe(link.host_dq_oe),
		.dev_dq_oe(link.dev_dq_oe), .serial_in_line(link.serial_in_line),
		.serial_out_line(link.serial_out_line));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (rd_valid === 1'b1)
			rq.push_back(rd_byte);
		if (cfg_updated === 1'b1)
			upd_count++;
		if (wr_take === 1'b1) begin
			wr_byte <= wbuf[widx + 1];
			widx    <= widx + 1;
		end
	end

	// ==================================================================
	// helpers
	task complete_run;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	function automatic logic [3:0] dummies(input logic [3:0] c, input logic [3:0] def);
		return (c == 4'h0 || c == 4'hf) ? def : c;
	endfunction

	task send(input logic [7:0] op, input logic ua, input logic [31:0] ad, input lane_t ln,
		input logic [3:0] dm, input logic [8:0] wb, input logic [15:0] rb, input logic [3:0] cc);
		int k;
		k = 0;
		rq.delete();
		do begin
			@(posedge core_clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 40000);
		cmd_valid    <= 1'b1;
		cmd_op       <= op;
		cmd_use_addr <= ua;
		cmd_addr     <= ad;
		cmd_lanes    <= ln;
		cmd_dummy    <= dm;
		cmd_wr_bytes <= wb;
		cmd_rd_bytes <= rb;
		cfg_code     <= cc;
		widx         <= 0;
		wr_byte      <= wbuf[0];
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge core_clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 40000);
		if (k >= 40000) begin
			err_count++;
			$display("ERROR at %0t: command did not finish", $time);
		end
	endtask

	task wren;
		send(OP_WREN, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0000, 4'h0);
	endtask

	task cfg_write(input logic [3:0] c);
		wren();
		send(OP_WRCFG, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h002, 16'h0000, c);
		cfg_writes++;
		repeat (8) @(posedge core_clk);
		check(cfg_word, {c, 12'hfff});
		check(write_latch, 1'b0);
		send(OP_RDCFG, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0002, 4'h0);
		check(rq.size(), 2);
		check({rq[0], rq[1]}, {c, 12'hfff});
	endtask

	task page_write(input logic [7:0] op, input lane_t ln, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			wbuf[i]                    = 8'($urandom);
			mem[(a[7:0] + i) % 256] = wbuf[i];
		end
		wren();
		send(op, 1'b1, a, ln, 4'h0, 9'(cnt), 16'h0000, 4'h0);
	endtask

	task read_back(input logic [7:0] op, input lane_t ln, input logic [3:0] dm, input int cnt);
		send(op, 1'b1, a, ln, dm, 9'h000, 16'(cnt), 4'h0);
		check(rq.size(), cnt);
		for (int i = 0; i < cnt; i++)
			check(rq[i], mem[(a[7:0] + i) % 256]);
	endtask

	// ==================================================================
	// main sequence
	initial begin
		void'($urandom(42022));
		{srst, cmd_valid, cmd_use_addr} = 3'b100;
		{cmd_op, wr_byte, cmd_addr, cmd_dummy, cfg_code} = '0;
		{cmd_wr_bytes, cmd_rd_bytes} = '0;
		cmd_lanes = LANE_X1;
		{err_count, checks_done, upd_count, cfg_writes, widx} = '0;
		// long enough for the link side to see three serial edges
		repeat (14) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		check(cfg_word, 16'hffff);
		send(OP_RDCFG, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0004, 4'h0);
		check(rq.size(), 4);
		check({rq[0], rq[1]}, 16'hffff);
		check({rq[2], rq[3]}, 16'h0000);
		// zero byte count: the host leaves the write enable off
		send(OP_WRCFG, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0000, 4'h3);
		repeat (8) @(posedge core_clk);
		check(cfg_word, 16'hffff);
		check(upd_count, 0);
		wren();
		repeat (4) @(posedge core_clk);
		check(write_latch, 1'b1);
		send(OP_RDSR, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0002, 4'h0);
		check(rq.size(), 2);
		check({rq[0][1], rq[1][1]}, 2'b11);
		send(OP_RDFSR, 1'b0, 32'h0, LANE_X1, 4'h0, 9'h000, 16'h0003, 4'h0);
		check(rq.size(), 3);
		check(rq[2] & 8'h81, 8'h80);
		for (int k = 0; k < 7; k++) begin
			code = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : (k == 2) ? 4'h1 : (k == 3) ? 4'he : 4'($urandom);
			cfg_write(code);
			a = $urandom;
			n = (k == 0) ? 1 : 1 + $urandom % 40;
			page_write(OP_QPROG, LANE_X4, n);
			read_back(OP_FREAD, LANE_X1, dummies(code, 4'h8), n);
			read_back(OP_QREAD, LANE_X4, dummies(code, 4'ha), n);
			read_back(OP_DREAD, LANE_X2, 4'ha, n);
		end
		a = $urandom;
		page_write(OP_DPROG, LANE_X2, 260);
		read_back(OP_FREAD, LANE_X1, dummies(code, 4'h8), 256);
		check(upd_count, cfg_writes);
		complete_run();
	end

	initial begin
		#(80000 * 20);
		err_count++;
		$display("ERROR at %0t: run timed out", $time);
		complete_run();
	end
endmodule
`default_nettype wire
